// file: design/ptt_timer.sv
module ptt_timer
   import ptt_pkg::*;
(
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // source pin and power state
   input wire logic input_pin_i,
   input wire logic sleep_i,
   // software side
   input wire ptt_cfg_s cfg_i,
   input wire logic cfg_wr_i,
   input wire ptt_wr_s wr_i,
   input wire logic pin_output_route_select_i,
   // results
   output logic [7:0] count_low_byte_o,
   output logic [7:0] count_high_or_period_byte_o,
   output logic output_level_status_o,
   output logic timer_toggle_output_o,
   output logic route_pin_o,
   output logic event_o
);
   logic src_raw;
   logic sync1_q;
   logic sync2_q;
   logic sync3_q;
   logic src_prev_q;
   logic edge_sync;
   logic edge_async;
   logic src_edge;
   logic scaler_clr;
   logic [PTT_PRE_W-1:0] pre_cnt_q;
   logic [PTT_PRE_W-1:0] pre_cnt_d;
   logic pre_tick;
   logic [PTT_PRE_W-1:0] pre_limit;
   logic [7:0] low_q;
   logic [7:0] low_d;
   logic [7:0] high_q;
   logic [7:0] high_d;
   logic match_ev;
   logic post_pulse;
   logic out_q;
   logic out_d;
   logic route_q;
   logic ev_q;

   // source polarity
   assign src_raw = (cfg_i.clock_source_select == PTT_CS_PIN_INV) ? ~input_pin_i : input_pin_i;

   // sync path: two flops then an edge detector on the second's output
   assign edge_sync = sync2_q & ~sync3_q & ~sleep_i;
   // async path: edge seen directly on the raw source, sleep not gating
   assign edge_async = src_raw & ~src_prev_q;
   assign src_edge = cfg_i.enable & (cfg_i.async_count_enable ? edge_async : edge_sync);

   assign scaler_clr = wr_i.wr_low | cfg_wr_i;

   // prescaler: ratio 2^n, counter kept internal
   assign pre_limit = PTT_PRE_W'((17'h00001 << cfg_i.prescale_select) - 17'h00001);
   always_comb begin
      pre_cnt_d = pre_cnt_q;
      pre_tick = 1'b0;
      if (scaler_clr) begin
         pre_cnt_d = PTT_PRE_RST;
      end else if (src_edge) begin
         if (pre_cnt_q >= pre_limit) begin
            pre_cnt_d = PTT_PRE_RST;
            pre_tick = 1'b1;
         end else begin
            pre_cnt_d = pre_cnt_q + 1'b1;
         end
      end
   end

   // count registers and match / rollover event
   always_comb begin
      low_d = low_q;
      high_d = high_q;
      match_ev = 1'b0;
      if (pre_tick) begin
         if (cfg_i.mode_16bit) begin
            {high_d, low_d} = {high_q, low_q} + 16'h0001;
            match_ev = ({high_q, low_q} == 16'hFFFF);
         end else if (low_q == high_q) begin
            low_d = 8'h00;
            match_ev = 1'b1;
         end else begin
            low_d = low_q + 8'h01;
         end
      end
      if (wr_i.wr_low) begin
         low_d = wr_i.wdata;
      end
      if (wr_i.wr_high) begin
         high_d = wr_i.wdata;
      end
   end

   // postscaler 1..16, in its own counter module
   ptt_scaler #(.W(4)) u_post (
      .core_clk_i(core_clk_i),
      .reset_n_i(reset_n_i),
      .clear_i(scaler_clr),
      .tick_i(match_ev),
      .limit_i(cfg_i.postscale_select),
      .pulse_o(post_pulse)
   );

   always_comb begin
      out_d = out_q;
      if (post_pulse) begin
         out_d = ~out_q;
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         sync3_q <= 1'b0;
         src_prev_q <= 1'b0;
         pre_cnt_q <= PTT_PRE_RST;
         low_q <= PTT_CNT_RST[7:0];
         high_q <= PTT_PER_RST;
         out_q <= 1'b0;
         route_q <= 1'b0;
         ev_q <= 1'b0;
      end else begin
         sync1_q <= src_raw;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         src_prev_q <= src_raw;
         pre_cnt_q <= pre_cnt_d;
         low_q <= low_d;
         high_q <= high_d;
         out_q <= out_d;
         route_q <= pin_output_route_select_i & out_d;
         ev_q <= post_pulse;
      end
   end

   // all outputs straight from flops
   assign count_low_byte_o = low_q;
   assign count_high_or_period_byte_o = high_q;
   assign output_level_status_o = out_q;
   assign timer_toggle_output_o = out_q;
   assign route_pin_o = route_q;
   assign event_o = ev_q;

   // a single core clock means "async" edges are still sampled here; a true
   // sleep-time counter would need the source as its own clock
   sync_no_sleep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (!cfg_i.async_count_enable && sleep_i) |-> !src_edge)
      else $error("sync edge counted during sleep");
   async_sleep_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (cfg_i.enable && cfg_i.async_count_enable && src_raw && !src_prev_q) |-> src_edge)
      else $error("async edge lost");
   one_per_clk_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (!cfg_i.async_count_enable && src_edge) |=> !edge_sync)
      else $error("two sync edges in a row");
   pre_clear_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      scaler_clr |=> pre_cnt_q == PTT_PRE_RST)
      else $error("prescaler not cleared");
   pre_bound_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pre_cnt_q <= pre_limit) || $changed(cfg_i))
      else $error("prescaler out of range");
   low_wrap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pre_tick && !cfg_i.mode_16bit && low_q == high_q && !wr_i.wr_low)
      |=> low_q == 8'h00)
      else $error("low byte did not wrap at match");
   roll_event_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pre_tick && cfg_i.mode_16bit && {high_q, low_q} == 16'hFFFF) |-> match_ev)
      else $error("rollover event missing");
   toggle_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      post_pulse |=> out_q != $past(out_q))
      else $error("output did not toggle");
   hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      !post_pulse |=> $stable(out_q))
      else $error("output toggled without postscaler pulse");
   match_ev_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (match_ev && cfg_i.postscale_select == 4'h0 && !scaler_clr) |=> ##1 out_q != $past(out_q, 2))
      else $error("1:1 postscale failed");

   // source polarity and count stepping
   pol_inv_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (cfg_i.clock_source_select == PTT_CS_PIN_INV) |-> src_raw == !input_pin_i)
      else $error("inverted source not inverted");
   pol_plain_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (cfg_i.clock_source_select == PTT_CS_PIN) |-> src_raw == input_pin_i)
      else $error("plain source altered");
   low_step_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pre_tick && !cfg_i.mode_16bit && low_q != high_q && !wr_i.wr_low)
      |=> low_q == $past(low_q) + 8'h01)
      else $error("low byte did not step");
   low_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (!pre_tick && !wr_i.wr_low) |=> $stable(low_q))
      else $error("low byte moved without a tick");
   count16_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pre_tick && cfg_i.mode_16bit && !wr_i.wr_low && !wr_i.wr_high)
      |=> {high_q, low_q} == $past({high_q, low_q}) + 16'h0001)
      else $error("16-bit count did not step");
   match8_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      (pre_tick && !cfg_i.mode_16bit && low_q == high_q) |-> match_ev)
      else $error("8-bit match event missing");

   // output side: route and event follow the toggle in the same cycle
   route_align_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ##1 route_q == ($past(pin_output_route_select_i) & out_q))
      else $error("routed pin disagrees with output");
   event_align_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
      ##1 ev_q == $past(post_pulse))
      else $error("event pulse out of step with toggle");

   sync_cov_c: cover property (@(posedge core_clk_i) !cfg_i.async_count_enable && pre_tick);
   async_cov_c: cover property (@(posedge core_clk_i) cfg_i.async_count_enable && sleep_i && src_edge);
   match8_cov_c: cover property (@(posedge core_clk_i) !cfg_i.mode_16bit && match_ev);
   toggle_cov_c: cover property (@(posedge core_clk_i) post_pulse);
   roll16_cov_c: cover property (@(posedge core_clk_i) cfg_i.mode_16bit && match_ev);
endmodule // ptt_timer

// file: design/ptt_pkg.sv
// Behaviour
// - Clock source code 000 passes the routed input pin straight through and code 001 inverts it.
// - With async counting off, the input clock is resynchronised to the system clock before it counts.
// - In synchronised operation the counter advances at most once per system clock.
// - In synchronised operation the counter does not advance while the device sleeps.
// - With async counting on, the counter advances on every rising edge of the source or prescaler output.
// - In async operation the counter keeps counting during sleep while the source runs.
// - The prescaler offers sixteen ratios from 1:1 to 1:32768 chosen by the prescale select field.
// - The prescaler counter is not readable or writable through any register.
// - The prescaler counter clears on a low count write, a control register write and any reset.
// - The postscaler offers sixteen ratios from 1:1 to 1:16 chosen by the postscale select field.
// - The postscaler counter clears on a low count write, a control register write and any reset.
// - In 8-bit mode a match of the low byte with the period byte makes an event for the postscaler.
// - In 16-bit mode the event occurs whenever the combined high and low count rolls over.
// - The timer output toggles once per postscaler period.
// - The timer output can be routed to a pin and its level is readable as a status bit.
package ptt_pkg;
   localparam logic [2:0] PTT_CS_PIN = 3'h0;
   localparam logic [2:0] PTT_CS_PIN_INV = 3'h1;
   localparam int PTT_PRE_W = 15;
   localparam logic [PTT_PRE_W-1:0] PTT_PRE_RST = 15'h0000;
   localparam logic [3:0] PTT_POST_RST = 4'h0;
   localparam logic [15:0] PTT_CNT_RST = 16'h0000;
   localparam logic [7:0] PTT_PER_RST = 8'hFF;

   typedef struct packed {
      logic [2:0] clock_source_select;
      logic async_count_enable;
      logic [3:0] prescale_select;
      logic [3:0] postscale_select;
      logic mode_16bit;
      logic enable;
   } ptt_cfg_s;

   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic [7:0] wdata;
   } ptt_wr_s;
endpackage

// file: design/ptt_scaler.sv
module ptt_scaler
   import ptt_pkg::*;
#(
   parameter int W = 4
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic reset_n_i,
   // control
   input wire logic clear_i,
   input wire logic tick_i,
   input wire logic [W-1:0] limit_i,
   // result
   output logic pulse_o
);
   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic pulse_d;
   logic pulse_q;

   // counter hidden: no port reads or loads it
   always_comb begin
      cnt_d = cnt_q;
      pulse_d = 1'b0;
      if (clear_i) begin
         cnt_d = '0;
      end else if (tick_i) begin
         if (cnt_q >= limit_i) begin
            cnt_d = '0;
            pulse_d = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_q <= '0;
         pulse_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulse_o = pulse_q;
endmodule // ptt_scaler

// file: verification/ptt_src_model.sv
module ptt_src_model (
   // clock
   input wire logic core_clk_i,
   // routed source pin
   output logic pin_o
);
   timeunit 1ns;
   timeprecision 1ns;
   initial pin_o = 1'b0;
   // n full periods of 8 clocks; the pin then holds its level
   task automatic run(input int n);
      repeat (2 * n) begin
         repeat (4) @(negedge core_clk_i);
         pin_o = ~pin_o;
      end
      repeat (6) @(negedge core_clk_i);
   endtask
endmodule // ptt_src_model

// file: verification/tb.sv
module tb
   import ptt_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic pin;
   logic slp = 1'b0;
   logic cwr = 1'b0;
   logic rte = 1'b1;
   logic exp_t = 1'b0;
   ptt_cfg_s cfg = '0;
   ptt_wr_s wr_s = '0;
   logic [7:0] lo, hi;
   logic lvl, tog, rpin, ev;
   int n_fail = 0;
   int n_tests = 0;
   int n_ev = 0;
   always #25 clk = ~clk;
   always @(posedge clk) begin
      if (ev === 1'b1) n_ev++;
   end
   ptt_timer u_dut (.core_clk_i(clk), .reset_n_i(rst_n), .input_pin_i(pin), .sleep_i(slp),
      .cfg_i(cfg), .cfg_wr_i(cwr), .wr_i(wr_s), .pin_output_route_select_i(rte),
      .count_low_byte_o(lo), .count_high_or_period_byte_o(hi), .output_level_status_o(lvl),
      .timer_toggle_output_o(tog), .route_pin_o(rpin), .event_o(ev));
   ptt_src_model u_src (.core_clk_i(clk), .pin_o(pin));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   // a control write also clears both scalers
   task automatic setup(input logic [2:0] cs, input logic asy, input logic [3:0] pre,
         input logic [3:0] post, input logic m16);
      @(negedge clk);
      cfg = '{cs, asy, pre, post, m16, 1'b1};
      cwr = 1'b1;
      @(negedge clk);
      cwr = 1'b0;
      n_ev = 0;
   endtask
   task automatic wr(input logic high, input logic [7:0] d);
      @(negedge clk);
      wr_s = '{~high, high, d};
      @(negedge clk);
      wr_s = '0;
   endtask
   task automatic sc_match;
      setup(PTT_CS_PIN, 1'b0, 4'h0, 4'h0, 1'b0);
      wr(1'b1, 8'h02);
      wr(1'b0, 8'h00);
      u_src.run(1);
      chk("low", 16'h0001, 16'(lo));
      u_src.run(2);
      chk("low", 16'h0000, 16'(lo));
      chk("events", 16'h0001, 16'(n_ev));
      exp_t = ~exp_t;
      chk("out", 16'(exp_t), 16'(tog));
      chk("status", 16'(exp_t), 16'(lvl));
      chk("route", 16'(exp_t), 16'(rpin));
   endtask
   task automatic sc_pre;
      setup(PTT_CS_PIN, 1'b0, 4'h2, 4'h0, 1'b1);
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h00);
      u_src.run(8);
      chk("low", 16'h0002, 16'(lo));
      u_src.run(3);
      wr(1'b0, 8'h00);
      u_src.run(1);
      chk("low", 16'h0000, 16'(lo));
   endtask
   // widest postscale ratio with a match on every edge
   task automatic sc_post;
      setup(PTT_CS_PIN, 1'b0, 4'h0, 4'hF, 1'b0);
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h00);
      u_src.run(15);
      chk("events", 16'h0000, 16'(n_ev));
      u_src.run(1);
      chk("events", 16'h0001, 16'(n_ev));
      exp_t = ~exp_t;
      chk("out", 16'(exp_t), 16'(tog));
   endtask
   task automatic sc_sleep;
      setup(PTT_CS_PIN, 1'b0, 4'h0, 4'h0, 1'b1);
      wr(1'b0, 8'h10);
      slp = 1'b1;
      u_src.run(2);
      chk("low", 16'h0010, 16'(lo));
      setup(PTT_CS_PIN, 1'b1, 4'h0, 4'h0, 1'b1);
      u_src.run(3);
      chk("low", 16'h0013, 16'(lo));
      slp = 1'b0;
   endtask
   // writes come first so a false edge from a wrong polarity stays in the prescaler
   task automatic sc_gate;
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h00);
      // code 110 is not the inverted code
      setup(3'h6, 1'b0, 4'h5, 4'h0, 1'b1);
      u_src.run(31);
      chk("low", 16'h0000, 16'(lo));
      setup(3'h6, 1'b0, 4'h5, 4'h0, 1'b1);
      u_src.run(1);
      chk("low", 16'h0000, 16'(lo));
      u_src.run(31);
      chk("low", 16'h0001, 16'(lo));
      // disabled: source edges are dropped
      @(negedge clk);
      cfg.prescale_select = 4'h0;
      cfg.enable = 1'b0;
      cwr = 1'b1;
      @(negedge clk);
      cwr = 1'b0;
      u_src.run(2);
      chk("low", 16'h0001, 16'(lo));
   endtask
   task automatic sc_roll;
      setup(PTT_CS_PIN_INV, 1'b0, 4'h0, 4'h0, 1'b1);
      // let the edge from the polarity change pass before loading
      repeat (5) @(negedge clk);
      chk("low", 16'h0002, 16'(lo));
      wr(1'b1, 8'hFF);
      wr(1'b0, 8'hFE);
      rte = 1'b0;
      u_src.run(1);
      chk("low", 16'h00FF, 16'(lo));
      u_src.run(1);
      chk("count", 16'h0000, {hi, lo});
      chk("events", 16'h0001, 16'(n_ev));
      exp_t = ~exp_t;
      chk("out", 16'(exp_t), 16'(tog));
      chk("route", 16'h0000, 16'(rpin));
   endtask
   // mid-run reset with both scalers part way through a period
   task automatic sc_reset;
      setup(PTT_CS_PIN, 1'b0, 4'h1, 4'h1, 1'b0);
      wr(1'b1, 8'h00);
      wr(1'b0, 8'h00);
      u_src.run(3);
      @(negedge clk);
      rst_n = 1'b0;
      @(negedge clk);
      rst_n = 1'b1;
      exp_t = 1'b0;
      chk("low", 16'h0000, 16'(lo));
      chk("high", 16'h00FF, 16'(hi));
      chk("out", 16'(exp_t), 16'(tog));
      wr(1'b1, 8'h01);
      u_src.run(1);
      chk("low", 16'h0000, 16'(lo));
      u_src.run(3);
      chk("out", 16'(exp_t), 16'(tog));
   endtask
   task automatic stop_test;
      if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      chk("low", 16'h0000, 16'(lo));
      chk("high", 16'h00FF, 16'(hi));
      chk("out", 16'h0000, 16'(tog));
      sc_match;
      sc_pre;
      sc_post;
      sc_sleep;
      sc_gate;
      sc_roll;
      sc_reset;
      stop_test;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test;
   end
endmodule // tb
